// ### logic/host_bus_register_and_burst_port.sv
// Host bus port: register transactions, coded-data bursts and an APB control slave.
`timescale 1ns/1ps
`default_nettype none
module host_bus_register_and_burst_port #(
  parameter int DEPTH = 16,
  parameter int BANK_WORDS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_n,
  input wire logic burst_master_select_n,
  input wire logic [31:0] host_data_address_bus_in,
  output logic [31:0] host_data_address_bus_out,
  output logic host_data_address_bus_oe,
  input wire logic [2:0] transfer_control_lines_in,
  output logic [2:0] transfer_control_lines_out,
  output logic transfer_control_lines_oe,
  output logic control_buffer_direction,
  output logic data_buffer_direction,
  output logic transfer_request_n,
  input wire logic core_push,
  input wire logic [31:0] core_push_data,
  input wire logic core_pop,
  output logic [31:0] core_pop_data,
  output logic core_pop_valid,
  output logic core_fifo_full,
  output logic core_fifo_empty
);
  localparam int LW = $clog2(DEPTH) + 1;
  localparam int BW = $clog2(BANK_WORDS);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  host_port_pkg::port_state_e state_reg, state_next;
  logic [31:0] ctrl_reg;
  logic bus_error_reg, bus_error_next;
  logic txn_out_reg, txn_out_next;
  logic txn_coded_reg, txn_coded_next;
  logic [BW-1:0] txn_index_reg, txn_index_next;
  logic [31:0] wdata_reg;
  logic first_wait_reg;
  logic [31:0] rd_word_reg, rd_word_next;
  logic [31:0] fifo_head, bank_rdata, push_word, status_word, prdata_next;
  logic [LW-1:0] fifo_level, req_threshold;
  logic fifo_full, fifo_empty, fifo_push, fifo_pop;
  logic ack_in, dir_in, accept, variant_two, decomp;
  logic coded_ready, reg_ready, burst_done, host_push, host_pop, bank_we;
  logic req_ready, bus_oe_next, tc_oe_next, dbd_next, treq_n_next;
  logic [31:0] bus_out_next;
  logic [2:0] tc_out_next;
  logic apb_access, apb_first, apb_commit, hit_ctrl, hit_stat, err_clear, err_set;

  // ----------------------------------------------------------------
  // Start cycle decode
  // ----------------------------------------------------------------
  // The host bus shares pclk, so its pins are read without synchronisers.
  assign ack_in = transfer_control_lines_in[host_port_pkg::ACK_IDX];
  assign dir_in = transfer_control_lines_in[host_port_pkg::DIR_IDX];
  assign variant_two = ctrl_reg[host_port_pkg::CTRL_VARIANT_BIT];
  assign decomp = ctrl_reg[host_port_pkg::CTRL_DECOMP_BIT];
  assign accept = (state_reg == host_port_pkg::st_idle) & ~start_n & ack_in; // RULE_03
  // The port drives data for a normal read or a burst read; the direction line flips sense.
  assign txn_out_next = accept ? ~(dir_in ^ burst_master_select_n) : txn_out_reg; // RULE_13
  assign txn_coded_next = accept ?
    (~burst_master_select_n | ~host_data_address_bus_in[host_port_pkg::CODED_SEL_BIT]) :
    txn_coded_reg; // RULE_11
  assign txn_index_next = accept ?
    host_data_address_bus_in[host_port_pkg::BANK_IDX_LSB +: BW] : txn_index_reg;

  // ----------------------------------------------------------------
  // Readiness of the data paths
  // ----------------------------------------------------------------
  // A coded-data access in the wrong mode never becomes ready, so it is never
  // acknowledged and the bus stays locked until reset or an APB write changes the mode; that is the intended hazard.
  assign coded_ready = txn_out_reg ? (~decomp & ~fifo_empty) : (decomp & ~fifo_full);
  assign reg_ready = ~txn_coded_reg | coded_ready; // RULE_25
  assign burst_done = (state_reg == host_port_pkg::st_burst) & ~ack_in;
  assign host_pop = ~decomp & txn_out_reg & txn_coded_reg &
    (((state_reg == host_port_pkg::st_reg_wait) & coded_ready) | burst_done);
  assign host_push = decomp & ~fifo_full & ~txn_out_reg & txn_coded_reg &
    ((state_reg == host_port_pkg::st_reg_ack) | burst_done); // RULE_20
  // Variant one took the data in the first wait cycle, variant two takes it now.
  assign push_word = (state_reg == host_port_pkg::st_reg_ack && !variant_two) ?
    wdata_reg : host_data_address_bus_in; // RULE_08
  assign bank_we = (state_reg == host_port_pkg::st_reg_ack) & ~txn_coded_reg & ~txn_out_reg;
  assign fifo_push = decomp ? host_push : (core_push & ~fifo_full);
  assign fifo_pop = decomp ? (core_pop & ~fifo_empty) : host_pop;

  // ----------------------------------------------------------------
  // Transaction sequencer
  // ----------------------------------------------------------------
  // Waits last as long as the data path needs; the host may not count on a figure.
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      host_port_pkg::st_idle: begin
        if (accept) begin
          state_next = burst_master_select_n ? host_port_pkg::st_reg_wait :
            host_port_pkg::st_burst;
        end
      end
      host_port_pkg::st_reg_wait: begin
        if (reg_ready) begin
          state_next = host_port_pkg::st_reg_ack; // RULE_06
        end
      end
      host_port_pkg::st_reg_ack: begin
        state_next = host_port_pkg::st_idle;
      end
      host_port_pkg::st_burst: begin
        if (!ack_in) begin
          state_next = host_port_pkg::st_idle; // RULE_21
        end
      end
    endcase
  end

  // Read data for the acknowledge cycle comes from the FIFO head or the bank.
  assign rd_word_next = (state_reg == host_port_pkg::st_reg_wait && reg_ready) ?
    (txn_coded_reg ? fifo_head : bank_rdata) : rd_word_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= host_port_pkg::st_idle;
      txn_out_reg <= 1'b0;
      txn_coded_reg <= 1'b0;
      txn_index_reg <= '0;
      first_wait_reg <= 1'b0;
      wdata_reg <= '0;
      rd_word_reg <= '0;
    end else begin
      state_reg <= state_next;
      txn_out_reg <= txn_out_next;
      txn_coded_reg <= txn_coded_next;
      txn_index_reg <= txn_index_next;
      first_wait_reg <= accept;
      rd_word_reg <= rd_word_next;
      if (first_wait_reg) begin
        wdata_reg <= host_data_address_bus_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  // Variant one drives the control lines from the wait state on, variant two only
  // in the acknowledge cycle; the control buffer direction is the inverse enable.
  assign tc_oe_next = (state_next == host_port_pkg::st_reg_ack) |
    ((state_next == host_port_pkg::st_reg_wait) & ~variant_two); // RULE_05
  assign tc_out_next = (state_next == host_port_pkg::st_reg_ack) ?
    host_port_pkg::TC_ACK : host_port_pkg::TC_WAIT_V1; // RULE_07
  assign bus_oe_next = txn_out_next & ((state_next == host_port_pkg::st_reg_ack) |
    (state_next == host_port_pkg::st_burst)); // RULE_14
  assign bus_out_next = (state_next == host_port_pkg::st_burst) ? fifo_head : rd_word_next;
  assign dbd_next = (state_next == host_port_pkg::st_idle) | ~txn_out_next; // RULE_13

  // Thresholds follow the request mask; decompression wants room, compression data.
  always_comb begin
    unique case (ctrl_reg[host_port_pkg::CTRL_REQSEL_LSB +: 2])
      2'h0: req_threshold = LW'(DEPTH / 4); // RULE_17
      2'h1: req_threshold = LW'(DEPTH / 2);
      2'h2: req_threshold = LW'((3 * DEPTH) / 4);
      2'h3: req_threshold = LW'(1);
    endcase
  end
  assign req_ready = decomp ? (fifo_level < req_threshold) :
    (fifo_level >= req_threshold); // RULE_16
  // The request drops as soon as a start is taken and stays off for the whole word.
  assign treq_n_next = ~(req_ready & (state_reg == host_port_pkg::st_idle) &
    (state_next == host_port_pkg::st_idle)); // RULE_19

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_data_address_bus_out <= '0;
      host_data_address_bus_oe <= 1'b0;
      transfer_control_lines_out <= host_port_pkg::TC_WAIT_V1;
      transfer_control_lines_oe <= 1'b0;
      control_buffer_direction <= 1'b1;
      data_buffer_direction <= 1'b1;
      transfer_request_n <= 1'b1;
    end else begin
      host_data_address_bus_out <= bus_out_next;
      host_data_address_bus_oe <= bus_oe_next;
      transfer_control_lines_out <= tc_out_next;
      transfer_control_lines_oe <= tc_oe_next;
      control_buffer_direction <= ~tc_oe_next;
      data_buffer_direction <= dbd_next;
      transfer_request_n <= treq_n_next; // RULE_10
    end
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  coded_data_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(fifo_push),
    .push_data(decomp ? push_word : core_push_data),
    .pop(fifo_pop),
    .head(fifo_head),
    .level(fifo_level),
    .full_reg(fifo_full),
    .empty_reg(fifo_empty)
  );

  host_register_bank #(.WORDS(BANK_WORDS), .WIDTH(32)) u_bank (
    .pclk(pclk),
    .presetn(presetn),
    .we(bank_we),
    .index(txn_index_reg),
    .wdata(push_word),
    .rdata(bank_rdata)
  );

  // Core side of the FIFO; the core must watch the flags before it pushes or pops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_pop_data <= '0;
      core_pop_valid <= 1'b0;
      core_fifo_full <= 1'b0;
      core_fifo_empty <= 1'b1;
    end else begin
      core_pop_valid <= decomp & fifo_pop;
      if (decomp && fifo_pop) begin
        core_pop_data <= fifo_head;
      end
      core_fifo_full <= fifo_full;
      core_fifo_empty <= fifo_empty;
    end
  end

  // ----------------------------------------------------------------
  // APB slave and bus error flag
  // ----------------------------------------------------------------
  // One wait state on every access keeps prdata a plain flip-flop.
  assign apb_access = psel & penable;
  assign apb_first = apb_access & ~pready;
  assign apb_commit = apb_access & pready & ~pslverr;
  assign hit_ctrl = (paddr == host_port_pkg::CTRL_OFFSET);
  assign hit_stat = (paddr == host_port_pkg::STATUS_OFFSET);
  assign status_word = {{(32 - host_port_pkg::STAT_LEVEL_LSB - LW){1'b0}}, fifo_level,
    6'h00, (state_reg != host_port_pkg::st_idle), bus_error_reg};
  assign prdata_next = ~apb_first ? prdata : hit_ctrl ? ctrl_reg :
    hit_stat ? status_word : 32'h0000_0000;
  assign err_set = burst_done & ~variant_two &
    (transfer_control_lines_in[1:0] != host_port_pkg::RESULT_OK); // RULE_24
  assign err_clear = apb_commit & pwrite & hit_stat & pwdata[host_port_pkg::STAT_ERR_BIT];
  // A new error in the clearing cycle survives the clear.
  assign bus_error_next = err_set | (bus_error_reg & ~err_clear);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= host_port_pkg::CTRL_RESET;
      bus_error_reg <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      bus_error_reg <= bus_error_next;
      prdata <= prdata_next;
      pready <= apb_first;
      pslverr <= apb_first & ~(hit_ctrl | hit_stat);
      if (apb_commit && pwrite && hit_ctrl) begin
        ctrl_reg <= {28'h000_0000, pwdata[3:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_start_ignored: assert property ((state_reg == host_port_pkg::st_idle) && !start_n && // RULE_03
    !ack_in |=> state_reg == host_port_pkg::st_idle && !transfer_control_lines_oe)
    else $error("start with acknowledge low was not ignored");
  a_ctrl_turnaround: assert property (accept && burst_master_select_n && !variant_two // RULE_05
    |=> !control_buffer_direction && transfer_control_lines_oe)
    else $error("control lines not turned after start");
  a_one_wait_state: assert property (accept && burst_master_select_n && // RULE_25
    !txn_coded_next |=> state_reg == host_port_pkg::st_reg_wait ##1
    state_reg == host_port_pkg::st_reg_ack)
    else $error("plain register did not take one wait state");
  a_read_ack_drive: assert property ((state_reg == host_port_pkg::st_reg_ack) && // RULE_07
    txn_out_reg |-> host_data_address_bus_oe && transfer_control_lines_oe &&
    transfer_control_lines_out == 3'h0)
    else $error("read acknowledge not driven correctly");
  a_request_release: assert property (accept |=> transfer_request_n[*2]) // RULE_19
    else $error("transfer request not released at start");
  a_buffer_decode: assert property (accept |=> // RULE_13
    data_buffer_direction == $past(transfer_control_lines_in[1] ^ burst_master_select_n))
    else $error("data buffer direction does not match cycle type");
  a_burst_source: assert property ((state_reg == host_port_pkg::st_burst) && txn_out_reg // RULE_14
    |-> host_data_address_bus_oe)
    else $error("burst source data not driven");
  a_burst_capture: assert property (burst_done && decomp && !txn_out_reg && !fifo_full // RULE_20
    |-> fifo_push ##1 state_reg == host_port_pkg::st_idle)
    else $error("burst write word not captured");
  a_bus_error_set: assert property (err_set |=> bus_error_reg) // RULE_24
    else $error("bus error flag not set");
  a_request_low: assert property (!transfer_request_n |-> $past(req_ready)) // RULE_16
    else $error("transfer request asserted without readiness");

  // Flag, request and turnaround checks beyond the main handshake; a clear that
  // meets a new error is left out, since the set wins there.
  a_busy_no_req: assert property (state_reg != host_port_pkg::st_idle |=> // RULE_19
    transfer_request_n)
    else $error("request while busy");

  a_error_clear: assert property (err_clear && !err_set |=> // RULE_24
    !bus_error_reg)
    else $error("error flag not cleared");

  a_ack_one_cycle: assert property (state_reg == host_port_pkg::st_reg_ack |=> // RULE_07
    state_reg == host_port_pkg::st_idle)
    else $error("ack cycle too long");

  a_burst_inputs: assert property (state_reg == host_port_pkg::st_burst |-> // RULE_11
    !transfer_control_lines_oe && control_buffer_direction)
    else $error("control lines driven in burst");

  // Covers for the main transfer kinds.
  c_reg_read: cover property (state_reg == host_port_pkg::st_reg_ack && txn_out_reg);
  c_reg_write: cover property (bank_we);
  c_burst_write: cover property (burst_done && host_push);
  c_burst_read: cover property (burst_done && host_pop);
  c_coded_read: cover property (host_pop && state_reg == host_port_pkg::st_reg_wait);
endmodule
`default_nettype wire

// ### shared/host_port_pkg.sv
// Constants, register map and state type of the host bus register and burst port.
// Behaviour
// RULE_01: Host opens a register access with address, direction line and start strobe.
// RULE_02: Write data replaces address by the first or the acknowledge falling edge.
// RULE_03: Start, direction and acknowledge are sampled; acknowledge low means start ignored.
// RULE_04: Host sets direction one for read, zero for write, acknowledge high.
// RULE_05: After start the control buffer direction turns so the port drives control lines.
// RULE_06: Any number of wait states may pass before the acknowledge cycle.
// RULE_07: Register read drives data, acknowledge low and result code zero.
// RULE_08: Register write acknowledges when ready; second variant captures data then.
// RULE_09: Host keeps write data on the bus until the acknowledge cycle ends.
// RULE_10: Transfer request output is low while the coded-data path can move data.
// RULE_11: Burst-master select low at start picks the coded-data FIFO, address ignored.
// RULE_12: In bursts the controller drives acknowledge low, and result lines on variant one.
// RULE_13: Data buffer direction follows the decoded cycle type table.
// RULE_14: As burst data source the port drives data after start until acknowledge.
// RULE_15: Controller selects burst mode only when the coded-data path is ready.
// RULE_16: Transfer request asserts by the threshold that the request mask selects.
// RULE_17: In decompression the request asserts while the FIFO is under a quarter.
// RULE_18: Controller sets direction, start and master select before the sampling edge.
// RULE_19: Transfer request is released once a start cycle is recognised.
// RULE_20: In a burst write the bus word enters the FIFO when acknowledge is low.
// RULE_21: Master select may stay low; raising it ends the burst after the current word.
// RULE_22: Controller keeps data and control lines valid until each data cycle ends.
// RULE_23: On variant one the master select is held high during decompression.
// RULE_24: Variant one sets the bus error flag if a burst result line is one.
// RULE_25: Every register except the coded-data port takes exactly one wait state.
package host_port_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_VARIANT_BIT = 0;
  localparam int CTRL_DECOMP_BIT = 1;
  localparam int CTRL_REQSEL_LSB = 2;
  localparam int STAT_ERR_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_LEVEL_LSB = 8;

  // ----------------------------------------------------------------
  // Host bus layout
  // ----------------------------------------------------------------
  localparam int ACK_IDX = 2;
  localparam int DIR_IDX = 1;
  localparam int CODED_SEL_BIT = 15;
  localparam int BANK_IDX_LSB = 2;
  localparam logic [1:0] RESULT_OK = 2'h0;
  localparam logic [2:0] TC_WAIT_V1 = 3'h4;
  localparam logic [2:0] TC_ACK = 3'h0;

  typedef enum logic [1:0] {st_idle, st_reg_wait, st_reg_ack, st_burst} port_state_e;

endpackage

// ### logic/coded_data_fifo.sv
// Coded-data FIFO held in flip-flops with registered full and empty flags.
`timescale 1ns/1ps
`default_nettype none
module coded_data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic [$clog2(DEPTH):0] level,
  output logic full_reg,
  output logic empty_reg
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = AW + 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [LW-1:0] level_next;
  logic do_push;
  logic do_pop;

  // Callers are expected to respect the flags; these guards only keep pointers sane.
  assign do_push = push & ~full_reg;
  assign do_pop = pop & ~empty_reg;
  assign head = mem_reg[rd_ptr_reg];
  assign level_next = level + LW'(do_push) - LW'(do_pop);

  // One storage word per entry, written only at the write pointer.
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        mem_reg[i] <= '0;
      end else if (do_push && wr_ptr_reg == AW'(i)) begin
        mem_reg[i] <= push_data;
      end
    end
  end

  // Pointers wrap at the depth, so a depth that is not a power of two also works.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      level <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      level <= level_next;
      full_reg <= (level_next == LW'(DEPTH));
      empty_reg <= (level_next == '0);
    end
  end
endmodule
`default_nettype wire

// ### logic/host_register_bank.sv
// Bank of general host-visible registers reached by register transactions.
`timescale 1ns/1ps
`default_nettype none
module host_register_bank #(
  parameter int WORDS = 8,
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic we,
  input wire logic [$clog2(WORDS)-1:0] index,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] word_reg [WORDS];

  assign rdata = word_reg[index];

  // Each word loads only when its own index is selected.
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        word_reg[i] <= '0;
      end else if (we && index == ($clog2(WORDS))'(i)) begin
        word_reg[i] <= wdata;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/host_bus_partner.sv
// Host and burst controller model facing the port's host bus pins.
`timescale 1ns/1ps
`default_nettype none
module host_bus_partner (
  input wire logic pclk,
  input wire logic [31:0] bus_out,
  input wire logic bus_oe,
  input wire logic [2:0] tc_out,
  input wire logic tc_oe,
  output logic start_n,
  output logic sel_n,
  output logic [31:0] bus_in,
  output logic [2:0] tc_in
);
  logic [2:0] tc_drv = 3'h4;
  logic [31:0] bus_drv = 32'h0000_0000;
  logic bus_en = 1'b0;
  logic hung = 1'b0;
  // The acknowledge line idles high; a released bus shows inverted stale data.
  assign tc_in = tc_oe ? tc_out : tc_drv;
  assign bus_in = bus_oe ? bus_out : (bus_en ? bus_drv : ~bus_drv);
  initial {start_n, sel_n} = 2'b11;
  // One transfer; a start with the acknowledge low skips the acknowledge wait and just idles for six cycles.
  task automatic op(input logic brst, input logic dir, input logic ak, input logic [31:0] a,
                    input logic [31:0] d, input int wt, input logic [1:0] res);
    int n;
    n = 0;
    sel_n <= !brst;
    tc_drv <= {ak, dir, 1'b0};
    bus_drv <= a;
    bus_en <= 1'b1;
    start_n <= 1'b0;
    @(posedge pclk);
    start_n <= 1'b1;
    sel_n <= 1'b1;
    tc_drv <= (brst && wt == 0) ? {1'b0, res} : 3'h4;
    bus_drv <= d;
    bus_en <= brst ? dir : !dir;
    if (brst) begin
      if (wt > 0) begin
        repeat (wt) @(posedge pclk);
        tc_drv <= {1'b0, res};
      end
      @(posedge pclk);
    end
    while (!brst && ak && !(tc_oe && tc_out == 3'h0) && n < 40) begin
      @(negedge pclk);
      n++;
    end
    hung = hung || n >= 40;
    if (!brst) repeat (ak ? 1 : 6) @(posedge pclk);
    tc_drv <= 3'h4;
    bus_en <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ### dv/host_bus_register_and_burst_port_bench.sv
// Self-checking bench for the host bus register and burst port.
`timescale 1ns/1ps
`default_nettype none
module host_bus_register_and_burst_port_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, cpd = 32'h0000_0000, prdata, bus_in, bus_out, pop_d;
  logic pready, pslverr, start_n, sel_n, bus_oe, tc_oe, cbd, dbd, req_n, pop_v, reg2 = 1'b0;
  logic push = 1'b0, pop = 1'b0, v2 = 1'b0, ful, emp;
  logic [2:0] tc_in, tc_out, st_q = 3'h0;
  logic [32:0] exp_q[$];
  int err_total = 0, compares = 0;
  always #2.5 pclk = ~pclk;
  host_bus_register_and_burst_port #(.DEPTH(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_n(start_n),
    .burst_master_select_n(sel_n), .host_data_address_bus_in(bus_in),
    .host_data_address_bus_out(bus_out), .host_data_address_bus_oe(bus_oe),
    .transfer_control_lines_in(tc_in), .transfer_control_lines_out(tc_out),
    .transfer_control_lines_oe(tc_oe), .control_buffer_direction(cbd),
    .data_buffer_direction(dbd), .transfer_request_n(req_n), .core_push(push),
    .core_push_data(cpd), .core_pop(pop), .core_pop_data(pop_d), .core_pop_valid(pop_v),
    .core_fifo_full(ful), .core_fifo_empty(emp));
  host_bus_partner p (.pclk(pclk), .bus_out(bus_out), .bus_oe(bus_oe), .tc_out(tc_out),
    .tc_oe(tc_oe), .start_n(start_n), .sel_n(sel_n), .bus_in(bus_in), .tc_in(tc_in));
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_req();
    int n;
    n = 0;
    while (req_n !== 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    chk("request", 33'h0, {32'h0, req_n});
  endtask
  task automatic summarize();
    if (p.hung || exp_q.size() != 0) err_total++;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Note each accepted start so the cycles after it can be judged.
  always @(posedge pclk) begin
    st_q <= {!start_n && tc_in[2], sel_n, tc_in[1]};
    reg2 <= st_q[2] && st_q[1];
  end
  // Results come in bus order, so the oldest note pairs with the next result seen.
  always @(negedge pclk) begin
    if (st_q[2]) begin
      chk("data dir", {32'h0, st_q[1] ? !st_q[0] : st_q[0]}, {32'h0, dbd});
      chk("ctrl dir", {32'h0, !(st_q[1] && !v2)}, {32'h0, cbd});
      chk("request", 33'h1, {32'h0, req_n});
    end
    if (reg2) chk("ack", 33'h8, {29'h0, tc_oe, tc_out});
    if ((pready && !pwrite) || (bus_oe && !tc_in[2]) || pop_v) begin
      if (exp_q.size() == 0) chk("spare result", 33'h0, 33'h1_0000_0000);
      else chk("result", exp_q.pop_front(), pop_v ? {1'b0, pop_d} :
               pready ? {pslverr, prdata} : {1'b0, bus_out});
    end
  end
  // Hang guard: a stuck run ends through the same closing report.
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    summarize();
  end
  initial begin
    logic [31:0] d;
    void'($urandom(48));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset dirs", 33'h3, {31'h0, cbd, dbd});
    apb(1'b1, 12'h000, 32'hffff_fff0);
    exp_q.push_back(33'h0);
    apb(1'b0, 12'h000, 32'h0);
    exp_q.push_back(33'h1_0000_0000);
    apb(1'b0, 12'h008, 32'h0);
    $display("test apb done");
    for (int v = 0; v < 2; v++) begin
      v2 = v[0];
      apb(1'b1, 12'h000, {31'h0, v2});
      p.op(1'b0, 1'b1, 1'b0, 32'h0000_8000, 32'h0, 0, 2'h0);
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        p.op(1'b0, 1'b0, 1'b1, 32'h0000_8000 | (i << 2), d, 0, 2'h0);
        exp_q.push_back({1'b0, d});
        p.op(1'b0, 1'b1, 1'b1, 32'h0000_8000 | (i << 2), 32'h0, 0, 2'h0);
      end
      $display("test register variant %0d done", v);
    end
    apb(1'b1, 12'h000, 32'h0000_000c);
    v2 = 1'b0;
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      exp_q.push_back({1'b0, d});
      push <= 1'b1;
      cpd <= d;
      @(posedge pclk);
      push <= 1'b0;
      @(posedge pclk);
    end
    chk("fifo flags", 33'h0, {31'h0, ful, emp});
    wait_req();
    p.op(1'b1, 1'b0, 1'b1, 32'h0, 32'h0, 0, 2'h0);
    p.op(1'b1, 1'b0, 1'b1, 32'h0, 32'h0, 3, 2'h1);
    p.op(1'b0, 1'b1, 1'b1, 32'h0, 32'h0, 0, 2'h0);
    exp_q.push_back(33'h1);
    apb(1'b0, 12'h004, 32'h0);
    apb(1'b1, 12'h004, 32'h0000_0001);
    exp_q.push_back(33'h0);
    apb(1'b0, 12'h004, 32'h0);
    $display("test burst read done");
    apb(1'b1, 12'h000, 32'h0000_0003);
    v2 = 1'b1;
    wait_req();
    for (int i = 0; i < 3; i++) begin
      d = $urandom;
      exp_q.push_back({1'b0, d});
      p.op(1'b1, 1'b1, 1'b1, 32'h0, d, $urandom_range(2), 2'h0);
    end
    repeat (3) begin
      pop <= 1'b1;
      @(posedge pclk);
      pop <= 1'b0;
      repeat (2) @(posedge pclk);
    end
    chk("fifo flags", 33'h1, {31'h0, ful, emp});
    $display("test burst write done");
    summarize();
  end
endmodule
`default_nettype wire
